// [logic/rfp_defines.svh]
`ifndef RFP_DEFINES_SVH
`define RFP_DEFINES_SVH
// byte addresses of the software registers
`define RFP_ADDR_CTRL 12'h000
`define RFP_ADDR_CURRENT 12'h008
`define RFP_ADDR_GPIO 12'h018
`define RFP_ADDR_SAFETY 12'h020
`define RFP_ADDR_STATUS 12'h024
// control register fields
`define RFP_CTRL_RED_SW 0
`define RFP_CTRL_GREEN_SW 1
`define RFP_CTRL_BLUE_SW 2
`define RFP_CTRL_MODE 3
`define RFP_CTRL_PWM 4
`define RFP_CTRL_GLOBAL 5
`define RFP_CTRL_FLASH 6
`define RFP_CTRL_EXT_LO 8
`define RFP_CTRL_EXT_HI 10
`define RFP_CTRL_W 11
`define RFP_CTRL_RESET 11'h008
// current register fields
`define RFP_CUR_W 6
`define RFP_CUR_RESET 6'h00
`define RFP_CUR_MAX 2'h3
// gpio register fields
`define RFP_GPIO_PIN_FN 4
// safety register fields
`define RFP_SAFE_W 3
// status register fields
`define RFP_STAT_TRIP 0
`define RFP_STAT_ARMED 1
// timing
`define RFP_CLOCK_HZ 50000000
`define RFP_PWM_HZ 20000
`define RFP_SAFETY_S 1
`endif

// [logic/rfp_pkg.sv]
package rfp_pkg;
	typedef enum logic [2:0] {
		RFP_IDLE = 3'b001,
		RFP_ARMED = 3'b010,
		RFP_SPENT = 3'b100
	} rfp_flash_e;
	typedef logic [1:0] rfp_level_t;
endpackage

// [logic/rgb_flash_pwm_safety_ctrl.sv]
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "rfp_defines.svh"
// Operation
// - pin feeds led path only when selected
// - output needs global enable and switch bit, except an armed flash on selected outputs
// - external gating only on selected outputs
// - external pwm pin is active high
// - internal pwm off: follow pin directly
// - internal pwm on: pass pwm while pin high
// - unselected enabled outputs stay on
// - flash trigger high forces selected outputs maximum
// - flash outputs off after trigger ends
// - new flash needs flash enable toggle
// - separate safety enable per colour
// - counter runs, current register access clears
// - one second trips selected outputs, sets status
// - flash mode counts only while trigger high
// - clearing safety bit restores that output
// - after trip only all-clear safety resets
// - mode bit zero means constant current
// - internal pwm runs at twenty kilohertz
// - switch bits enable their own outputs
// - current fields two bits per colour
module rgb_flash_pwm_safety_ctrl #(
	parameter int SAFETY_CYCLES = `RFP_CLOCK_HZ * `RFP_SAFETY_S,
	parameter int PWM_CYCLES = `RFP_CLOCK_HZ / `RFP_PWM_HZ,
	parameter logic [7:0] PWM_DUTY = 8'h80
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic gpio0_in,
	output logic red_sink_output,
	output logic green_sink_output,
	output logic blue_sink_output,
	output logic [1:0] red_level,
	output logic [1:0] green_level,
	output logic [1:0] blue_level,
	output logic output_mode_select
);
	// counters are 32 and 16 bits wide; refuse what they cannot hold
	if (SAFETY_CYCLES < 2 || PWM_CYCLES < 4 || PWM_CYCLES > 65535) begin : g_bad
		$error("rgb_flash_pwm_safety_ctrl: bad parameter");
	end

	localparam logic [31:0] SAFE_LAST = 32'(SAFETY_CYCLES - 1);
	localparam logic [15:0] PWM_LAST = 16'(PWM_CYCLES - 1);
	localparam logic [15:0] PWM_HIGH = 16'((PWM_CYCLES * PWM_DUTY) / 256);

	logic [`RFP_CTRL_W-1:0] ctrl;
	logic [`RFP_CUR_W-1:0] current;
	logic pinFunction;
	logic [`RFP_SAFE_W-1:0] safetyEnable;
	logic safetyTripped;
	logic [31:0] safetyCount;
	logic [15:0] pwmCount;
	logic pwmWave;
	logic pinMeta, pinSync, pinPrev;
	rfp_pkg::rfp_flash_e flashState;
	logic access, wrEn, curTouch;
	logic extPin, trigRise, trigFall, flashActive;
	logic [2:0] swBits, extSel, ledOn;
	logic [31:0] readMux;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
		hit = (a == r);
	endfunction

	assign access = psel && penable;
	assign wrEn = access && pwrite;
	assign curTouch = access && hit(paddr, `RFP_ADDR_CURRENT);
	assign swBits = ctrl[`RFP_CTRL_BLUE_SW:`RFP_CTRL_RED_SW];
	assign extSel = ctrl[`RFP_CTRL_EXT_HI:`RFP_CTRL_EXT_LO];
	// a deselected pin reads low so it cannot trigger or gate
	assign extPin = pinFunction && pinSync;
	assign trigRise = extPin && !pinPrev;
	assign trigFall = !extPin && pinPrev;
	assign flashActive = (flashState == rfp_pkg::RFP_ARMED) && extPin;

	// apb slave: zero wait states, unmapped reads zero with error
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				prdata <= readMux;
				pslverr <= !(hit(paddr, `RFP_ADDR_CTRL) ||
					hit(paddr, `RFP_ADDR_CURRENT) ||
					hit(paddr, `RFP_ADDR_GPIO) ||
					hit(paddr, `RFP_ADDR_SAFETY) ||
					hit(paddr, `RFP_ADDR_STATUS));
			end
		end
	end

	always_comb begin
		readMux = 32'h0;
		case (paddr)
			`RFP_ADDR_CTRL: readMux[`RFP_CTRL_W-1:0] = ctrl;
			`RFP_ADDR_CURRENT: readMux[`RFP_CUR_W-1:0] = current;
			`RFP_ADDR_GPIO: readMux[`RFP_GPIO_PIN_FN] = pinFunction;
			`RFP_ADDR_SAFETY: readMux[`RFP_SAFE_W-1:0] = safetyEnable;
			`RFP_ADDR_STATUS: begin
				readMux[`RFP_STAT_TRIP] = safetyTripped;
				readMux[`RFP_STAT_ARMED] = (flashState == rfp_pkg::RFP_ARMED);
			end
			default: readMux = 32'h0;
		endcase
	end

	// the write lands on the access edge, pready already high
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl <= `RFP_CTRL_RESET;
			current <= `RFP_CUR_RESET;
			pinFunction <= 1'b0;
			safetyEnable <= '0;
		end else if (wrEn && pready) begin
			case (paddr)
				`RFP_ADDR_CTRL: ctrl <= pwdata[`RFP_CTRL_W-1:0];
				`RFP_ADDR_CURRENT: current <= pwdata[`RFP_CUR_W-1:0];
				`RFP_ADDR_GPIO: pinFunction <= pwdata[`RFP_GPIO_PIN_FN];
				`RFP_ADDR_SAFETY: safetyEnable <= pwdata[`RFP_SAFE_W-1:0];
				default: ;
			endcase
		end
	end

	// two-stage pin synchroniser
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pinMeta <= 1'b0;
			pinSync <= 1'b0;
			pinPrev <= 1'b0;
		end else begin
			pinMeta <= gpio0_in;
			pinSync <= pinMeta;
			pinPrev <= extPin;
		end
	end

	// flash arms once the enable is set and the pin is low; one pulse per arming
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			flashState <= rfp_pkg::RFP_IDLE;
		end else if (!ctrl[`RFP_CTRL_FLASH]) begin
			flashState <= rfp_pkg::RFP_IDLE;
		end else begin
			case (flashState)
				rfp_pkg::RFP_IDLE: begin
					if (!extPin)
						flashState <= rfp_pkg::RFP_ARMED;
				end
				rfp_pkg::RFP_ARMED: begin
					if (trigFall)
						flashState <= rfp_pkg::RFP_SPENT;
				end
				rfp_pkg::RFP_SPENT: flashState <= rfp_pkg::RFP_SPENT;
				default: flashState <= rfp_pkg::RFP_IDLE;
			endcase
		end
	end

	// internal pwm, free running
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pwmCount <= 16'h0;
			pwmWave <= 1'b0;
		end else begin
			pwmCount <= (pwmCount == PWM_LAST) ? 16'h0 : pwmCount + 16'h1;
			pwmWave <= (pwmCount < PWM_HIGH);
		end
	end

	// safety counter; trip holds until every safety bit is cleared
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			safetyCount <= 32'h0;
			safetyTripped <= 1'b0;
		end else if (safetyEnable == '0) begin
			safetyCount <= 32'h0;
			safetyTripped <= 1'b0;
		end else if (!safetyTripped) begin
			if (safetyCount == SAFE_LAST) begin
				safetyTripped <= 1'b1;
			end else if (ctrl[`RFP_CTRL_FLASH]) begin
				if (trigRise)
					safetyCount <= 32'h0;
				else if (extPin)
					safetyCount <= safetyCount + 32'h1;
			end else if (curTouch) begin
				safetyCount <= 32'h0;
			end else begin
				safetyCount <= safetyCount + 32'h1;
			end
		end
	end

	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_led
			logic gated, normal, flashed;
			always_comb begin
				if (!extSel[i])
					gated = 1'b1;
				else if (ctrl[`RFP_CTRL_PWM])
					gated = pwmWave && extPin;
				else
					gated = extPin;
				if (ctrl[`RFP_CTRL_FLASH] && extSel[i] &&
					flashState == rfp_pkg::RFP_SPENT)
					gated = 1'b0;
				normal = ctrl[`RFP_CTRL_GLOBAL] && swBits[i] && gated;
				flashed = flashActive && extSel[i];
				ledOn[i] = (normal || flashed) &&
					!(safetyTripped && safetyEnable[i]);
			end
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			red_sink_output <= 1'b0;
			green_sink_output <= 1'b0;
			blue_sink_output <= 1'b0;
			red_level <= 2'h0;
			green_level <= 2'h0;
			blue_level <= 2'h0;
			output_mode_select <= 1'b1;
		end else begin
			red_sink_output <= ledOn[0];
			green_sink_output <= ledOn[1];
			blue_sink_output <= ledOn[2];
			red_level <= (flashActive && extSel[0]) ? `RFP_CUR_MAX : current[5:4];
			green_level <= (flashActive && extSel[1]) ? `RFP_CUR_MAX : current[3:2];
			blue_level <= (flashActive && extSel[2]) ? `RFP_CUR_MAX : current[1:0];
			output_mode_select <= ctrl[`RFP_CTRL_MODE];
		end
	end
endmodule

// [dv/rfp_properties.sv]
`timescale 1ns/1ps
module rfp_properties (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic gpio0_in,
	input wire logic red_sink_output,
	input wire logic [1:0] red_level,
	input wire logic output_mode_select
);
	// shadow of written fields, so outputs can be tied to their cause
	logic [10:0] ctl;
	logic [5:0] cur;
	logic safR;
	logic pinFn;
	wire wr = psel && penable && pready && pwrite;
	wire mapped = paddr inside {12'h000, 12'h008, 12'h018, 12'h020, 12'h024};
	wire on = ctl[5] && ctl[0] && !ctl[6] && !ctl[4] && !safR;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctl <= 11'h008;
			cur <= 6'h00;
			safR <= 1'b0;
			pinFn <= 1'b0;
		end else if (wr) begin
			case (paddr)
			12'h000: ctl <= pwdata[10:0];
			12'h008: cur <= pwdata[5:0];
			12'h018: pinFn <= pwdata[4];
			12'h020: safR <= pwdata[0];
			default: ;
			endcase
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_ready; psel && !penable |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("late ready");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready too long");
	property p_err; pready |-> pslverr == !mapped; endproperty
	a_err: assert property (p_err) else $error("bad error flag");
	property p_off; (!ctl[5] && !ctl[6])[*5] |-> !red_sink_output; endproperty
	a_off: assert property (p_off) else $error("lit while off");
	property p_on; (on && !ctl[8])[*5] |-> red_sink_output; endproperty
	a_on: assert property (p_on) else $error("steady led dark");
	// pin sampled into two sync flops, then the output flop
	property p_fol;
		(on && ctl[8] && pinFn)[*6] |-> red_sink_output == $past(gpio0_in, 3);
	endproperty
	a_fol: assert property (p_fol) else $error("pin not followed");
	property p_mode; $stable(ctl)[*3] |-> output_mode_select == ctl[3]; endproperty
	a_mode: assert property (p_mode) else $error("mode wrong");
	property p_lvl; ($stable(cur) && !ctl[6])[*3] ##0 red_sink_output |-> red_level == cur[5:4]; endproperty
	a_lvl: assert property (p_lvl) else $error("level wrong");
endmodule
bind rgb_flash_pwm_safety_ctrl rfp_properties u_props (.clock(clock),
	.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.gpio0_in(gpio0_in), .red_sink_output(red_sink_output),
	.red_level(red_level), .output_mode_select(output_mode_select));

// [dv/rfp_trigger_host.sv]
`timescale 1ns/1ps
module rfp_trigger_host (
	input wire logic clock,
	input wire logic level,
	output logic pin
);
	// low from power-up so flash can be armed safely
	initial pin = 1'b0;
	always @(posedge clock) begin
		pin <= level;
	end
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
	logic clock, rst_n, psel, penable, pwrite, lvl, pin, err, oms;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr;
	logic [2:0] sink;
	logic [1:0] rl;
	logic [10:0] c;
	int fails, cmp_count, n;
	rgb_flash_pwm_safety_ctrl #(.SAFETY_CYCLES(100), .PWM_CYCLES(20))
	u_rgb_flash_pwm_safety_ctrl (.clock(clock), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .gpio0_in(pin),
		.red_sink_output(sink[0]), .green_sink_output(sink[1]),
		.blue_sink_output(sink[2]), .red_level(rl), .green_level(),
		.blue_level(), .output_mode_select(oms));
	rfp_trigger_host u_host (.clock(clock), .level(lvl), .pin(pin));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task automatic chk(input string nm, input logic [32:0] s, e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input int d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	// gated outputs follow the pin, the others stay steady
	function automatic logic [2:0] leds(input logic [10:0] k, input logic p);
		return k[5] ? k[2:0] & ~(k[10:8] & {3{~p}}) : 3'h0;
	endfunction
	task automatic conclude;
		if (fails == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge clock);
		fails++;
		conclude();
	end
	initial begin
		{rst_n, psel, penable, pwrite, lvl, paddr, pwdata} = '0;
		fails = 0;
		cmp_count = 0;
		void'($urandom(32'h2a33));
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		chk("reset", {sink, oms}, 4'h1);
		bus(0, 12'h004, 0);
		chk("unmapped", {err, rd}, 33'h100000000);
		repeat (8) begin
			c = 11'($urandom) & 11'h02f;
			n = $urandom & 63;
			bus(1, 12'h000, c);
			bus(1, 12'h008, n);
			repeat (5) @(posedge clock);
			chk("leds", sink, leds(c, 0));
			chk("mode", oms, c[3]);
			if (sink[0] === 1'b1)
				chk("level", rl, n[5:4]);
		end
		c = 11'h127;
		bus(1, 12'h018, 32'h10);
		bus(1, 12'h000, c);
		repeat (12) begin
			lvl <= 1'($urandom);
			repeat (6) @(posedge clock);
			chk("gate", sink, leds(c, pin));
		end
		bus(1, 12'h000, 32'h137);
		for (int p = 0; p < 2; p++) begin
			lvl <= p[0];
			repeat (6) @(posedge clock);
			n = 0;
			repeat (40) begin
				@(posedge clock);
				n += sink[0];
			end
			chk("pwm", n, p ? 20 : 0);
		end
		lvl <= 1'b0;
		bus(1, 12'h000, 32'h21);
		bus(1, 12'h020, 32'h1);
		repeat (3) begin
			repeat (60) @(posedge clock);
			bus(0, 12'h008, 0);
		end
		chk("kept", sink[0], 1);
		repeat (110) @(posedge clock);
		bus(0, 12'h024, 0);
		chk("trip", {sink[0], rd}, 1);
		bus(1, 12'h020, 0);
		bus(0, 12'h024, 0);
		chk("restore", {sink[0], rd}, 33'h100000000);
		// register flash: full current through the current register, then off
		bus(1, 12'h008, 32'h30);
		repeat (3) @(posedge clock);
		chk("regflash", {sink[0], rl}, 7);
		bus(1, 12'h000, 32'h20);
		repeat (3) @(posedge clock);
		chk("regstop", sink[0], 0);
		bus(1, 12'h008, 0);
		bus(1, 12'h000, 32'h160);
		for (int k = 0; k < 4; k++) begin
			if (k > 1) begin
				bus(1, 12'h000, 32'h120);
				bus(1, 12'h000, 32'h160);
			end
			if (k == 3)
				bus(1, 12'h020, 32'h1);
			lvl <= 1'b1;
			repeat (8) @(posedge clock);
			chk("fire", {sink[0], rl}, k == 1 ? 0 : 7);
			repeat (k == 3 ? 112 : 0) @(posedge clock);
			chk("long", sink[0], k != 3 && k != 1);
			lvl <= 1'b0;
			repeat (8) @(posedge clock);
			chk("after", sink[0], 0);
		end
		conclude();
	end
endmodule
